// ---- rcs_seq.sv ----
/*
 * Reset cause and start-up sequencer: merges reset sources, runs the
 * power-up delay and oscillator start-up timers, records causes.
 * Assumes analog detectors, pins and oscillators arrive asynchronously;
 * watchdog, sleep and wake events come from logic on i_mclk.
 */
// Decided for this implementation: the address map and the address-and-strobe port.
// Functional notes
// - Record seven distinct reset causes
// - Unaffected registers get no reset at all
// - Reset-state load on POR, MASTER_CLEAR_PIN, WDT, BOR
// - Wake-reset config 1: watchdog wake from sleep resumes, no reset
// - Glitch filter on master-clear input
// - Hold reset while power-on detect low
// - Wake-reset config 0: wake event resets
// - Wake-reset config 0: wake pin change in sleep signals wake
// - Wake reset clears wake cause flag
// - Delay timer 64 ms, only POR/BOR
// - Chip held in reset while delay counts
// - Delay config bit set disables timer
// - Watchdog reset never drives master-clear pin
// - Pin select clear: tie inactive, pull-up
// - Mode 01: software bit enables brown-out
// - Sleep-gated mode: off in sleep, on wake
// - Brown-out past minimum duration resets
// - Stay in reset until above threshold
// - Brown-out during delay restarts the delay
// - Delay after POR, then start-up timer
// - External clock, no delay: no time-out
// - Time-outs run independent of master-clear
// - Two-speed start: run during start-up timer
// - Brown-out mode encoding 11,10,01,00
// - Power-on flag 0 after POR, sticky
`timescale 1ns/1ps
`include "rcs_regs.svh"

module rcs_seq import rcs_pkg::*; #(
	parameter int P_PDT_TICKS = `RCS_PDT_TICKS,
	parameter int P_OST_TICKS = `RCS_OST_TICKS
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port
	input wire logic [`RCS_ADDR_W-1:0] i_addr,
	input wire logic [`RCS_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`RCS_DATA_W-1:0] o_rdata,
	// Supply detectors, pins and oscillators
	input wire logic i_por_ok,
	input wire logic i_bod_low,
	input wire logic i_master_clear_pin_n,
	input wire logic i_wake_change_pin,
	input wire logic i_low_freq_internal_osc,
	input wire logic i_osc_clk,
	// Core side events
	input wire logic i_watchdog_timeout,
	input wire logic i_sleep,
	input wire logic i_wake_event,
	// Reset and wake outputs
	output logic o_core_rst,
	output logic o_regs_rst,
	output logic o_run_internal_oscillator,
	output logic o_wake,
	output logic o_ioc_wake,
	output logic o_master_clear_pin_pull_en
);

	// ==========================================================
	// Declarations
	localparam logic [`RCS_TMR_W-1:0] PDT_LAST =
		`RCS_TMR_W'(P_PDT_TICKS - 1);
	localparam logic [`RCS_TMR_W-1:0] OST_LAST =
		`RCS_TMR_W'(P_OST_TICKS - 1);
	localparam logic [`RCS_FCNT_W-1:0] MASTER_CLEAR_PIN_CYC =
		`RCS_FCNT_W'(`RCS_MASTER_CLEAR_PIN_FILT_CYC);
	localparam logic [`RCS_FCNT_W-1:0] BOD_CYC =
		`RCS_FCNT_W'(`RCS_BOD_MIN_CYC);

	logic por_ok_s, bod_low_s, master_clear_pin_n_s, wake_s, lf_s, osc_s;
	logic wake_q_r, lf_q_r, osc_q_r, sleep_q_r;
	logic lf_tick, osc_tick, pin_edge;
	rcs_cfg_t cfg_r;
	rcs_power_control_reg_t power_control_reg_r;
	rcs_state_t state_r, state_nxt;
	rcs_cause_t cause_r;
	logic [`RCS_TMR_W-1:0] tmr_r;
	logic [`RCS_FCNT_W-1:0] mcnt_r, bcnt_r;
	logic master_clear_pin_act, master_clear_pin_q_r, master_clear_pin_evt;
	logic bor_en, bor_trip, bor_act_r, bor_evt;
	logic por_low, hold_any, need_tmr_r, pdt_en;
	logic ioc, wake_rst, wdt_run_rst, wdt_slp_rst, wdt_wake, soft_evt;
	logic core_rst_r, run_int_r, wake_r, ioc_r;
	logic to_n_r, pd_n_r;
	logic [`RCS_DATA_W-1:0] rdata_r;

	// ==========================================================
	// Input synchronisers
	rcs_sync3 #(.P_INIT(1'b0)) u_sync_por (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_por_ok), .o_level(por_ok_s));
	rcs_sync3 #(.P_INIT(1'b0)) u_sync_bod (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_bod_low), .o_level(bod_low_s));
	rcs_sync3 #(.P_INIT(1'b1)) u_sync_master_clear_pin (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_master_clear_pin_n), .o_level(master_clear_pin_n_s));
	rcs_sync3 #(.P_INIT(1'b0)) u_sync_wake (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_wake_change_pin), .o_level(wake_s));
	rcs_sync3 #(.P_INIT(1'b0)) u_sync_lf (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_low_freq_internal_osc), .o_level(lf_s));
	rcs_sync3 #(.P_INIT(1'b0)) u_sync_osc (
		.i_mclk(i_mclk), .i_rst(i_rst),
		.i_async(i_osc_clk), .o_level(osc_s));

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wake_q_r <= 1'b0;
			lf_q_r <= 1'b0;
			osc_q_r <= 1'b0;
			sleep_q_r <= 1'b0;
			master_clear_pin_q_r <= 1'b0;
		end else begin
			wake_q_r <= wake_s;
			lf_q_r <= lf_s;
			osc_q_r <= osc_s;
			sleep_q_r <= i_sleep;
			master_clear_pin_q_r <= master_clear_pin_act;
		end
	end

	assign lf_tick = lf_s & ~lf_q_r;
	assign osc_tick = osc_s & ~osc_q_r;
	assign pin_edge = wake_s ^ wake_q_r;

	// ==========================================================
	// Master-clear filter; short pulses never reach the count
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mcnt_r <= '0;
		end else if (master_clear_pin_n_s || !cfg_r.master_clear_pin_select) begin
			mcnt_r <= '0;
		end else if (mcnt_r != MASTER_CLEAR_PIN_CYC) begin
			mcnt_r <= mcnt_r + 1'b1;
		end
	end

	assign master_clear_pin_act = (mcnt_r == MASTER_CLEAR_PIN_CYC);
	assign master_clear_pin_evt = master_clear_pin_act & ~master_clear_pin_q_r;
	assign o_master_clear_pin_pull_en = ~cfg_r.master_clear_pin_select;

	// ==========================================================
	// Brown-out enable and duration check
	always_comb begin
		case (cfg_r.brownout_mode_select)
			`RCS_BOR_ON: bor_en = 1'b1;
			`RCS_BOR_RUN: bor_en = ~i_sleep;
			`RCS_BOR_SW: bor_en = power_control_reg_r.sw_brownout_enable;
			default: bor_en = 1'b0;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bcnt_r <= '0;
		end else if (!(bod_low_s && bor_en)) begin
			bcnt_r <= '0;
		end else if (bcnt_r != BOD_CYC) begin
			bcnt_r <= bcnt_r + 1'b1;
		end
	end

	assign bor_trip = (bcnt_r == BOD_CYC);
	assign bor_evt = bor_trip & ~bor_act_r;

	// Held until supply is back above threshold
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bor_act_r <= 1'b0;
		end else if (bor_trip) begin
			bor_act_r <= 1'b1;
		end else if (!bod_low_s) begin
			bor_act_r <= 1'b0;
		end
	end

	// ==========================================================
	// Sleep, wake and watchdog events
	// Watchdog acts on the core reset or, in sleep with config 1, on the wake output; the pin has no driver
	assign ioc = i_sleep & ~cfg_r.wake_reset_config_n & pin_edge;
	assign wake_rst = i_sleep & ~cfg_r.wake_reset_config_n &
		(i_wake_event | ioc);
	assign wdt_run_rst = i_watchdog_timeout & ~i_sleep;
	assign wdt_slp_rst = i_watchdog_timeout & i_sleep &
		~cfg_r.wake_reset_config_n;
	assign wdt_wake = i_watchdog_timeout & i_sleep &
		cfg_r.wake_reset_config_n;
	assign soft_evt = wdt_run_rst | wdt_slp_rst | wake_rst;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			wake_r <= 1'b0;
			ioc_r <= 1'b0;
		end else begin
			wake_r <= wdt_wake | (i_sleep & cfg_r.wake_reset_config_n &
				i_wake_event);
			ioc_r <= ioc;
		end
	end

	// ==========================================================
	// Start-up sequencer
	// Falling supply is caught by brown-out and by power-on detect going low, in any state
	assign por_low = ~por_ok_s;
	assign hold_any = por_low | bor_act_r | bor_trip |
		(bor_en & bod_low_s);
	assign pdt_en = ~cfg_r.powerup_delay_config;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_HOLD: begin
				if (!hold_any) begin
					if (need_tmr_r && pdt_en) begin
						state_nxt = ST_PDT;
					end else if (need_tmr_r && cfg_r.osc_xtal) begin
						state_nxt = ST_OST;
					end else begin
						state_nxt = ST_RUN;
					end
				end
			end
			ST_PDT: begin
				if (hold_any) begin
					state_nxt = ST_HOLD;
				end else if (lf_tick && tmr_r == PDT_LAST) begin
					state_nxt = cfg_r.osc_xtal ? ST_OST : ST_RUN;
				end
			end
			ST_OST: begin
				if (hold_any) begin
					state_nxt = ST_HOLD;
				end else if (osc_tick && tmr_r == OST_LAST) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				if (por_low || bor_trip || soft_evt) begin
					state_nxt = ST_HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= ST_HOLD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timer restarts from zero on every state change
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tmr_r <= '0;
		end else if (state_nxt != state_r || state_r == ST_HOLD) begin
			tmr_r <= '0;
		end else if (state_r == ST_PDT && lf_tick) begin
			tmr_r <= tmr_r + 1'b1;
		end else if (state_r == ST_OST && osc_tick) begin
			tmr_r <= tmr_r + 1'b1;
		end
	end

	// Timers owed only after power-on or brown-out
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			need_tmr_r <= 1'b1;
		end else if (por_low || bor_trip) begin
			need_tmr_r <= 1'b1;
		end else if (state_r != ST_RUN && state_nxt == ST_RUN) begin
			need_tmr_r <= 1'b0;
		end
	end

	// ==========================================================
	// Core reset: async assert via i_rst, release on the clock
	// Master-clear asserts and holds the core reset in any state; time-outs keep running
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			core_rst_r <= 1'b1;
			run_int_r <= 1'b0;
		end else begin
			core_rst_r <= master_clear_pin_act | (state_r == ST_HOLD) |
				(state_r == ST_PDT) |
				(state_r == ST_OST & ~cfg_r.two_spd);
			run_int_r <= (state_r == ST_OST) & cfg_r.two_spd;
		end
	end

	assign o_core_rst = i_rst | core_rst_r;
	// Reset-state class only; unaffected class is left unwired
	assign o_regs_rst = o_core_rst;
	assign o_run_internal_oscillator = run_int_r;
	assign o_wake = wake_r;
	assign o_ioc_wake = ioc_r;

	// ==========================================================
	// Cause recording; hardware events win over software writes
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cause_r <= CS_POR;
		end else if (por_low) begin
			cause_r <= CS_POR;
		end else if (bor_evt) begin
			cause_r <= CS_BOR;
		end else if (master_clear_pin_evt) begin
			cause_r <= i_sleep ? CS_MASTER_CLEAR_PIN_SLEEP : CS_MASTER_CLEAR_PIN_RUN;
		end else if (wdt_run_rst) begin
			cause_r <= CS_WDT_RUN;
		end else if (wdt_slp_rst) begin
			cause_r <= CS_WDT_SLEEP;
		end else if (wake_rst) begin
			cause_r <= CS_WAKE;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			power_control_reg_r <= rcs_power_control_reg_t'(`RCS_POWER_CONTROL_REG_RST);
		end else begin
			if (i_wr && i_addr == `RCS_OFS_POWER_CONTROL_REG) begin
				power_control_reg_r <= rcs_power_control_reg_t'(i_wdata[`RCS_POWER_CONTROL_REG_W-1:0]);
			end
			if (por_low) begin
				power_control_reg_r.poweron_flag_n <= 1'b0;
			end
			if (bor_evt) begin
				power_control_reg_r.brownout_flag_n <= 1'b0;
			end
			if (wake_rst) begin
				power_control_reg_r.wake_reset_cause_flag <= 1'b0;
			end
		end
	end

	// Watchdog and sleep flags, active low
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			to_n_r <= 1'b1;
			pd_n_r <= 1'b1;
		end else begin
			if (por_low || bor_evt) begin
				to_n_r <= 1'b1;
				pd_n_r <= 1'b1;
			end else begin
				if (i_watchdog_timeout) begin
					to_n_r <= 1'b0;
				end else if (wake_rst) begin
					to_n_r <= 1'b1;
				end
				if (i_sleep && !sleep_q_r) begin
					pd_n_r <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Register port
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cfg_r <= rcs_cfg_t'(`RCS_CFG_RST);
		end else if (i_wr && i_addr == `RCS_OFS_CFG) begin
			cfg_r <= rcs_cfg_t'(i_wdata[`RCS_CFG_W-1:0]);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r <= '0;
		end else if (!i_rd) begin
			rdata_r <= '0;
		end else if (i_addr == `RCS_OFS_CFG) begin
			rdata_r <= {1'b0, cfg_r};
		end else if (i_addr == `RCS_OFS_POWER_CONTROL_REG) begin
			rdata_r <= {4'h0, power_control_reg_r};
		end else if (i_addr == `RCS_OFS_STAT) begin
			rdata_r <= {1'b0, cause_r, to_n_r, pd_n_r, state_r};
		end else begin
			rdata_r <= '0;
		end
	end

	assign o_rdata = rdata_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	property p_pdt_hold;
		state_r == ST_PDT |=> o_core_rst;
	endproperty
	a_pdt_hold: assert property (p_pdt_hold)
		else $error("core released during delay timer");

	property p_master_clear_pin_tie;
		!cfg_r.master_clear_pin_select |-> !master_clear_pin_act && o_master_clear_pin_pull_en;
	endproperty
	a_master_clear_pin_tie: assert property (p_master_clear_pin_tie)
		else $error("master-clear active while tied off");

	property p_bor_restart;
		state_r == ST_PDT && bor_trip |=> state_r == ST_HOLD ##1 tmr_r == 0;
	endproperty
	a_bor_restart: assert property (p_bor_restart)
		else $error("delay timer not restarted on brown-out");

	property p_por_hold;
		por_low |=> state_r == ST_HOLD ##1 o_core_rst;
	endproperty
	a_por_hold: assert property (p_por_hold)
		else $error("core not held while power-on detect low");

	property p_bor_sw;
		cfg_r.brownout_mode_select == `RCS_BOR_SW |->
			bor_en == power_control_reg_r.sw_brownout_enable;
	endproperty
	a_bor_sw: assert property (p_bor_sw)
		else $error("software brown-out enable ignored");

	property p_bor_sleep;
		cfg_r.brownout_mode_select == `RCS_BOR_RUN |-> bor_en == !i_sleep;
	endproperty
	a_bor_sleep: assert property (p_bor_sleep)
		else $error("sleep-gated brown-out wrong");

	property p_bor_off;
		cfg_r.brownout_mode_select == `RCS_BOR_OFF |-> !bor_en && !bor_trip;
	endproperty
	a_bor_off: assert property (p_bor_off)
		else $error("brown-out active in disabled mode");

	property p_wdt_wake;
		wdt_wake && state_r == ST_RUN && !hold_any && !i_wake_event
			|=> state_r == ST_RUN && $stable(cause_r) && o_wake;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake)
		else $error("watchdog wake caused a reset");

	property p_wake_flag;
		wake_rst |=> !power_control_reg_r.wake_reset_cause_flag;
	endproperty
	a_wake_flag: assert property (p_wake_flag)
		else $error("wake cause flag not cleared");

	property p_por_flag;
		por_low |=> !power_control_reg_r.poweron_flag_n && cause_r == CS_POR;
	endproperty
	a_por_flag: assert property (p_por_flag)
		else $error("power-on flag not cleared");

	property p_two_spd;
		state_r == ST_OST && cfg_r.two_spd && !master_clear_pin_act
			|=> !core_rst_r && o_run_internal_oscillator;
	endproperty
	a_two_spd: assert property (p_two_spd)
		else $error("no early run during start-up timer");

	property p_ioc;
		i_sleep && pin_edge && !cfg_r.wake_reset_config_n |=> o_ioc_wake;
	endproperty
	a_ioc: assert property (p_ioc)
		else $error("pin change in sleep gave no wake signal");

	property p_no_tmo;
		state_r == ST_HOLD && !hold_any && !cfg_r.osc_xtal && !pdt_en
			|=> state_r == ST_RUN;
	endproperty
	a_no_tmo: assert property (p_no_tmo)
		else $error("time-out applied with none configured");

	c_pdt_done: cover property (state_r == ST_PDT ##1 state_r == ST_RUN);
	c_ost_done: cover property (state_r == ST_OST ##1 state_r == ST_RUN);
	c_wake_rst: cover property (wake_rst ##1 state_r == ST_HOLD);
	c_master_clear_pin: cover property (master_clear_pin_evt && state_r == ST_RUN);

endmodule : rcs_seq

// ---- rcs_regs.svh ----
/*
 * Register offsets, reset values and timing counts of the reset cause
 * and start-up sequencer. Assumes a 10 MHz system clock.
 */
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// ==========================================================
// Register port
`define RCS_ADDR_W 4
`define RCS_DATA_W 8
`define RCS_OFS_CFG 4'h0
`define RCS_OFS_POWER_CONTROL_REG 4'h1
`define RCS_OFS_STAT 4'h2

// ==========================================================
// Field widths and reset values
`define RCS_CFG_W 7
`define RCS_CFG_RST 7'h1B
`define RCS_POWER_CONTROL_REG_W 4
`define RCS_POWER_CONTROL_REG_RST 4'hD

// ==========================================================
// Brown-out mode select codes
`define RCS_BOR_OFF 2'h0
`define RCS_BOR_SW 2'h1
`define RCS_BOR_RUN 2'h2
`define RCS_BOR_ON 2'h3

// ==========================================================
// Timing
`define RCS_CLK_HZ 10000000
`define RCS_LFOSC_HZ 31000
`define RCS_PDT_MS 64
`define RCS_PDT_TICKS ((`RCS_PDT_MS * `RCS_LFOSC_HZ) / 1000)
`define RCS_OST_TICKS 1024
`define RCS_TMR_W 12
`define RCS_MASTER_CLEAR_PIN_FILT_NS 2000
`define RCS_MASTER_CLEAR_PIN_FILT_CYC \
	((`RCS_MASTER_CLEAR_PIN_FILT_NS * (`RCS_CLK_HZ / 1000000) + 999) / 1000)
`define RCS_BOD_MIN_NS 1000
`define RCS_BOD_MIN_CYC \
	((`RCS_BOD_MIN_NS * (`RCS_CLK_HZ / 1000000) + 999) / 1000)
`define RCS_FCNT_W 8

`endif

// ---- rcs_pkg.sv ----
/*
 * Types of the reset cause and start-up sequencer.
 * Assumes rcs_regs.svh for widths and codes.
 */
package rcs_pkg;

	// ==========================================================
	// Sequencer states and reset causes
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_PDT,
		ST_OST,
		ST_RUN
	} rcs_state_t;

	typedef enum logic [2:0] {
		CS_POR,
		CS_WAKE,
		CS_WDT_RUN,
		CS_WDT_SLEEP,
		CS_MASTER_CLEAR_PIN_RUN,
		CS_MASTER_CLEAR_PIN_SLEEP,
		CS_BOR
	} rcs_cause_t;

	// ==========================================================
	// Configuration and power control layouts, LSB last
	typedef struct packed {
		logic osc_xtal;
		logic two_spd;
		logic wake_reset_config_n;
		logic master_clear_pin_select;
		logic powerup_delay_config;
		logic [1:0] brownout_mode_select;
	} rcs_cfg_t;

	typedef struct packed {
		logic sw_brownout_enable;
		logic wake_reset_cause_flag;
		logic poweron_flag_n;
		logic brownout_flag_n;
	} rcs_power_control_reg_t;

endpackage : rcs_pkg

// ---- rcs_sync3.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to i_mclk.
 */
`timescale 1ns/1ps

module rcs_sync3 #(
	parameter logic P_INIT = 1'b0
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Async in, clean level out
	input wire logic i_async,
	output logic o_level
);

	logic [2:0] ff_r;

	// ==========================================================
	// Stage chain; first stage feeds only the second
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ff_r <= {3{P_INIT}};
		end else begin
			ff_r <= {ff_r[1:0], i_async};
		end
	end

	// Change accepted once stages two and three agree
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_level <= P_INIT;
		end else if (ff_r[1] == ff_r[2]) begin
			o_level <= ff_r[2];
		end
	end

endmodule : rcs_sync3

// ---- rcs_env.sv ----
/*
 * Partner model: oscillators and master-clear pin of the sequencer.
 * Assumes a 100 ns i_mclk; the bench commands the pin level.
 */
`timescale 1ns/1ps

module rcs_env (
	// Clock and command
	input wire logic i_mclk,
	input wire logic i_pin_low,
	// Towards the sequencer
	output logic o_lfosc,
	output logic o_osc,
	output logic o_pin_n
);
	// ======
	// Free running oscillators, scaled down: 1600 ns and 800 ns
	// Slow enough to survive the input filter of the sequencer
	logic [3:0] div_r;
	initial div_r = 4'h0;
	always @(posedge i_mclk) begin
		div_r <= div_r + 4'h1;
	end
	assign o_lfosc = div_r[3];
	assign o_osc = div_r[2];
	// Pin has an external pull-up: high unless held low
	assign o_pin_n = ~i_pin_low;
endmodule : rcs_env

// ---- rcs_seq_test.sv ----
/*
 * Self-checking bench of rcs_seq with its partner model.
 * Assumes timer counts shortened to 4; stimulus on i_mclk.
 */
`timescale 1ns/1ps
`include "rcs_regs.svh"

module rcs_seq_test;
	// ======
	// Stimulus and monitors
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic por = 1'b0, bod = 1'b0, pin_low = 1'b0, wpin = 1'b0;
	logic wdt = 1'b0, slp = 1'b0, wev = 1'b0, prv = 1'b1;
	logic core_rst, regs_rst, rio, wk, ioc, pull, lf, osc, pin_n;
	// Entries: mode, sw enable, sleep, reset expected
	logic [4:0] bt [7] = '{5'h19, 5'h04, 5'h08, 5'h0D, 5'h16, 5'h11, 5'h1B};
	int n_mismatch = 0, checked = 0, cyc = 0;
	int nrst = 0, nioc = 0, nwk = 0, n, r0, r1;

	rcs_seq #(.P_PDT_TICKS(4), .P_OST_TICKS(4)) i_dut (
		.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_por_ok(por),
		.i_bod_low(bod), .i_master_clear_pin_n(pin_n),
		.i_wake_change_pin(wpin), .i_low_freq_internal_osc(lf),
		.i_osc_clk(osc), .i_watchdog_timeout(wdt), .i_sleep(slp),
		.i_wake_event(wev), .o_core_rst(core_rst), .o_regs_rst(regs_rst),
		.o_run_internal_oscillator(rio), .o_wake(wk), .o_ioc_wake(ioc),
		.o_master_clear_pin_pull_en(pull));
	rcs_env i_env (.i_mclk(clk), .i_pin_low(pin_low), .o_lfosc(lf),
		.o_osc(osc), .o_pin_n(pin_n));

	always #50 clk = ~clk;
	// One-cycle outputs are counted in the cycle they stand
	always @(negedge clk) begin
		cyc++;
		if (core_rst === 1'b1 && prv !== 1'b1) nrst++;
		prv = core_rst;
		if (ioc === 1'b1) nioc++;
		if (wk === 1'b1) nwk++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim;
		end
	end

	// ======
	// Access and compare tasks
	task automatic chk(input logic [7:0] got, exp, m);
		checked++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rng(input int v, lo, hi);
		checked++;
		if (v < lo || v > hi) begin
			n_mismatch++;
			$display("unexpected at %0t: count %0d", $time, v);
		end
	endtask : rng
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [7:0] e, m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e, m);
	endtask : rreg
	task automatic wait_rst(input logic lv, output int k);
		k = 0;
		while (core_rst !== lv && k < 3000) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_rst
	task automatic bpulse(input int k);
		@(posedge clk) bod <= 1'b1;
		repeat (k) @(posedge clk);
		bod <= 1'b0;
	endtask : bpulse
	task automatic mpulse(input int k);
		@(posedge clk) pin_low <= 1'b1;
		repeat (k) @(posedge clk);
		pin_low <= 1'b0;
	endtask : mpulse
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ======
	// Test sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk({7'h0, core_rst}, 8'h01, 8'hFF);
		rreg(`RCS_OFS_CFG, 8'h1B, 8'hFF);
		rreg(`RCS_OFS_POWER_CONTROL_REG, 8'h00, 8'h02);
		@(posedge clk) por <= 1'b1;
		wait_rst(1'b0, n);
		rng(n, 40, 400);
		rreg(`RCS_OFS_STAT, 8'h0F, 8'hFF);
		rreg(4'hF, 8'h00, 8'hFF);
		wreg(`RCS_OFS_STAT, 8'hFF);
		rreg(`RCS_OFS_STAT, 8'h0F, 8'hFF);
		wreg(`RCS_OFS_POWER_CONTROL_REG, 8'h0F);
		rreg(`RCS_OFS_POWER_CONTROL_REG, 8'h0F, 8'hFF);
		// Watchdog in run: no delay timer, flags sticky
		@(posedge clk) wdt <= 1'b1;
		@(posedge clk) wdt <= 1'b0;
		wait_rst(1'b1, n);
		rng(n, 0, 3);
		chk({7'h0, regs_rst}, 8'h01, 8'hFF);
		wait_rst(1'b0, n);
		rng(n, 0, 3);
		rreg(`RCS_OFS_STAT, 8'h27, 8'hFF);
		rreg(`RCS_OFS_POWER_CONTROL_REG, 8'h0F, 8'hFF);
		// Master-clear: glitch, long hold, internal tie-off
		r0 = nrst;
		mpulse(10);
		repeat (40) @(posedge clk);
		chk(8'(nrst - r0), 8'h00, 8'hFF);
		mpulse(60);
		wait_rst(1'b0, n);
		rng(n, 0, 30);
		chk(8'(nrst - r0), 8'h01, 8'hFF);
		rreg(`RCS_OFS_STAT, 8'h40, 8'h70);
		wreg(`RCS_OFS_CFG, 8'h13);
		@(negedge clk);
		chk({7'h0, pull}, 8'h01, 8'hFF);
		r0 = nrst;
		mpulse(60);
		repeat (30) @(posedge clk);
		chk(8'(nrst - r0), 8'h00, 8'hFF);
		// Brown-out: short dip, then every mode
		wreg(`RCS_OFS_CFG, 8'h1B);
		r0 = nrst;
		bpulse(3);
		repeat (30) @(posedge clk);
		chk(8'(nrst - r0), 8'h00, 8'hFF);
		foreach (bt[i]) begin
			wreg(`RCS_OFS_CFG, {6'h06, bt[i][4:3]});
			wreg(`RCS_OFS_POWER_CONTROL_REG, {4'h0, bt[i][2], 3'h7});
			@(posedge clk) slp <= bt[i][1];
			r0 = nrst;
			bpulse(30);
			repeat (12) @(posedge clk);
			slp <= 1'b0;
			repeat (120) @(posedge clk);
			chk(8'(nrst - r0), {7'h0, bt[i][0]}, 8'hFF);
		end
		rreg(`RCS_OFS_STAT, 8'h60, 8'h70);
		rreg(`RCS_OFS_POWER_CONTROL_REG, 8'h00, 8'h01);
		// Second dip while the delay runs restarts it
		bpulse(30);
		repeat (20) @(posedge clk);
		bpulse(30);
		chk({7'h0, core_rst}, 8'h01, 8'hFF);
		wait_rst(1'b0, n);
		rng(n, 40, 400);
		wreg(`RCS_OFS_CFG, 8'h1F);
		bpulse(30);
		wait_rst(1'b0, n);
		rng(n, 0, 20);
		wreg(`RCS_OFS_CFG, 8'h7B);
		bpulse(30);
		n = 0;
		while (rio !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		rng(n, 40, 400);
		wait_rst(1'b0, n);
		rng(n, 0, 3);
		repeat (80) @(posedge clk);
		// Wake reset armed: pin change, then wake event
		wreg(`RCS_OFS_CFG, 8'h0B);
		rreg(`RCS_OFS_STAT, 8'h03, 8'h03);
		@(posedge clk) slp <= 1'b1;
		r0 = nrst;
		r1 = nioc;
		repeat (8) @(posedge clk);
		wpin <= 1'b1;
		wait_rst(1'b1, n);
		@(posedge clk) slp <= 1'b0;
		wait_rst(1'b0, n);
		chk(8'(nioc - r1), 8'h01, 8'hFF);
		chk(8'(nrst - r0), 8'h01, 8'hFF);
		rreg(`RCS_OFS_POWER_CONTROL_REG, 8'h00, 8'h04);
		rreg(`RCS_OFS_STAT, 8'h10, 8'h70);
		wreg(`RCS_OFS_POWER_CONTROL_REG, 8'h0F);
		@(posedge clk) slp <= 1'b1;
		r0 = nrst;
		@(posedge clk) wev <= 1'b1;
		@(posedge clk) wev <= 1'b0;
		wait_rst(1'b1, n);
		@(posedge clk) slp <= 1'b0;
		wait_rst(1'b0, n);
		chk(8'(nrst - r0), 8'h01, 8'hFF);
		// Watchdog and master-clear in sleep, wake reset armed
		@(posedge clk) slp <= 1'b1;
		r0 = nrst;
		@(posedge clk) wdt <= 1'b1;
		@(posedge clk) wdt <= 1'b0;
		wait_rst(1'b1, n);
		@(posedge clk) slp <= 1'b0;
		wait_rst(1'b0, n);
		chk(8'(nrst - r0), 8'h01, 8'hFF);
		rreg(`RCS_OFS_STAT, 8'h30, 8'h70);
		@(posedge clk) slp <= 1'b1;
		mpulse(60);
		wait_rst(1'b0, n);
		@(posedge clk) slp <= 1'b0;
		rreg(`RCS_OFS_STAT, 8'h50, 8'h70);
		// Watchdog wake without reset
		wreg(`RCS_OFS_CFG, 8'h1B);
		@(posedge clk) slp <= 1'b1;
		r0 = nrst;
		r1 = nwk;
		@(posedge clk) wdt <= 1'b1;
		@(posedge clk) wdt <= 1'b0;
		repeat (20) @(posedge clk);
		slp <= 1'b0;
		chk(8'(nwk - r1), 8'h01, 8'hFF);
		chk(8'(nrst - r0), 8'h00, 8'hFF);
		end_sim;
	end
endmodule : rcs_seq_test
